// ### src/ccb_top.v
`include "ccb_regs.vh"

module ccb_top #(
  parameter COEF_W = 24,
  parameter STARTUP_CYC = `CCB_STARTUP_US * `CCB_CLK_MHZ,
  // Identification value is arbitrary.
  parameter [7:0] CHIP_ID = 8'h5a
) (
  // Clock and reset
  input wire mclk_i,
  input wire rst_n_i,
  // Serial interface pins
  input wire sck_i,
  input wire serial_in_line_i,
  input wire chip_select_n_i,
  output wire sdo_o,
  output wire sdo_oe_o,
  // Standby pin
  input wire standby_pin_i,
  // Converter result, same clock domain, left aligned in 24 bits
  input wire [23:0] conv_data_i,
  input wire conv_valid_i,
  // Corrected result and status
  output wire [23:0] corr_data_o,
  output wire corr_valid_o,
  output wire ready_o,
  output wire standby_o,
  output wire analog_pd_o,
  output wire cal_set_two_o
);

  localparam DW = (COEF_W == 16) ? 16 : 24;
  localparam integer FRAME_END_I = `CCB_CMD_BITS + DW - 1;
  localparam [5:0] FRAME_END = FRAME_END_I[5:0];
  localparam [23:0] FMASK = (COEF_W == 20) ? `CCB_MASK20 : `CCB_MASK_ALL;
  localparam [23:0] GAIN_RST = (COEF_W == 16) ? `CCB_GAIN16_RST : `CCB_GAIN_RST;
  localparam integer START_LAST_I = STARTUP_CYC - 1;
  localparam [12:0] START_LAST = START_LAST_I[12:0];
  localparam [1:0] ST_START = 2'b00;
  localparam [1:0] ST_IDLE = 2'b01;
  localparam [1:0] ST_STANDBY_PIN = 2'b10;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  reg sck_s1_reg, sck_s2_reg, sck_s3_reg;
  reg cs_s1_reg, cs_s2_reg, cs_s3_reg;
  reg sdi_s1_reg, sdi_s2_reg;
  reg standby_pin_s1_reg, standby_pin_s2_reg;

  always @(posedge mclk_i) begin
    if (!rst_n_i) begin
      sck_s1_reg <= 1'b1;
      sck_s2_reg <= 1'b1;
      sck_s3_reg <= 1'b1;
      cs_s1_reg <= 1'b1;
      cs_s2_reg <= 1'b1;
      cs_s3_reg <= 1'b1;
      sdi_s1_reg <= 1'b0;
      sdi_s2_reg <= 1'b0;
      standby_pin_s1_reg <= 1'b0;
      standby_pin_s2_reg <= 1'b0;
    end else begin
      sck_s1_reg <= sck_i;
      sck_s2_reg <= sck_s1_reg;
      sck_s3_reg <= sck_s2_reg;
      cs_s1_reg <= chip_select_n_i;
      cs_s2_reg <= cs_s1_reg;
      cs_s3_reg <= cs_s2_reg;
      sdi_s1_reg <= serial_in_line_i;
      sdi_s2_reg <= sdi_s1_reg;
      standby_pin_s1_reg <= standby_pin_i;
      standby_pin_s2_reg <= standby_pin_s1_reg;
    end
  end

  wire sck_fall = sck_s3_reg & ~sck_s2_reg;
  wire cs_fall = cs_s3_reg & ~cs_s2_reg;

  // ----------------------------------------------------------------
  // Power state: startup wait, idle, standby
  // ----------------------------------------------------------------
  reg [1:0] st_reg, st_next;
  reg [12:0] wait_reg;

  always @* begin
    st_next = st_reg;
    case (st_reg)
      ST_START: begin
        if (standby_pin_s2_reg)
          st_next = ST_STANDBY_PIN;
        else if (wait_reg == START_LAST)
          st_next = ST_IDLE;
      end
      ST_IDLE: begin
        if (standby_pin_s2_reg)
          st_next = ST_STANDBY_PIN;
      end
      ST_STANDBY_PIN: begin
        // Leaving standby repeats the startup wait, since all circuits were off.
        if (!standby_pin_s2_reg)
          st_next = ST_START;
      end
      default: st_next = ST_START;
    endcase
  end

  always @(posedge mclk_i) begin
    if (!rst_n_i) begin
      st_reg <= ST_START;
      wait_reg <= 13'h0000;
    end else begin
      st_reg <= st_next;
      if (st_reg == ST_START)
        wait_reg <= wait_reg + 13'h0001;
      else
        wait_reg <= 13'h0000;
    end
  end

  wire active = (st_reg == ST_IDLE);

  // ----------------------------------------------------------------
  // Serial frame: command byte, then one data word
  // ----------------------------------------------------------------
  reg [5:0] bcnt_reg;
  reg [23:0] rx_reg;
  reg [7:0] cmd_reg;
  reg [23:0] tx_reg;
  reg sdo_oe_reg;

  reg [23:0] off1_reg, off2_reg, gain_coef_set_one_reg, gain_coef_set_two_reg;
  reg [7:0] ctrl_reg;
  reg slp_reg;
  reg [23:0] data_reg;

  wire [23:0] rx_new = {rx_reg[22:0], sdi_s2_reg};
  wire [7:0] cmd_new = rx_new[7:0];
  wire [23:0] wr_al = (DW == 16) ? {rx_new[15:0], 8'h00} : (rx_new & FMASK);
  wire [3:0] wr_adr = cmd_reg[3:0];
  wire take = active & ~cs_s2_reg & sck_fall;
  wire wr_done = take & (bcnt_reg == FRAME_END) & ~cmd_reg[`CCB_CMD_RD];

  // Small registers sit in the low bits of the word, shifted to the frame MSB.
  function [23:0] small_tx;
    input [15:0] v;
    begin
      small_tx = (DW == 16) ? {v, 8'h00} : {8'h00, v};
    end
  endfunction

  reg [23:0] rd_word;
  always @* begin
    case (cmd_new[3:0])
      `CCB_ADR_CTRL: rd_word = small_tx({8'h00, ctrl_reg});
      `CCB_ADR_DATA: rd_word = data_reg;
      `CCB_ADR_OPT: rd_word = small_tx({CHIP_ID, 7'h00, slp_reg});
      `CCB_ADR_GAIN_COEF_SET_ONE: rd_word = gain_coef_set_one_reg;
      `CCB_ADR_GAIN_COEF_SET_TWO: rd_word = gain_coef_set_two_reg;
      `CCB_ADR_OFF1: rd_word = off1_reg;
      `CCB_ADR_OFF2: rd_word = off2_reg;
      default: rd_word = 24'h000000;
    endcase
  end

  always @(posedge mclk_i) begin
    if (!rst_n_i) begin
      bcnt_reg <= 6'h00;
      rx_reg <= 24'h000000;
      cmd_reg <= 8'h00;
      tx_reg <= 24'h000000;
      sdo_oe_reg <= 1'b0;
    end else begin
      sdo_oe_reg <= active & ~cs_s2_reg;
      if (cs_s2_reg | cs_fall) begin
        bcnt_reg <= 6'h00;
        tx_reg <= 24'h000000;
      end else if (take) begin
        rx_reg <= rx_new;
        if (bcnt_reg <= FRAME_END)
          bcnt_reg <= bcnt_reg + 6'h01;
        if (bcnt_reg == `CCB_CMD_BITS - 6'd1) begin
          cmd_reg <= cmd_new;
          tx_reg <= cmd_new[`CCB_CMD_RD] ? rd_word : 24'h000000;
        end else if (bcnt_reg >= `CCB_CMD_BITS) begin
          tx_reg <= {tx_reg[22:0], 1'b0};
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  always @(posedge mclk_i) begin
    if (!rst_n_i) begin
      off1_reg <= `CCB_OFF_RST;
      off2_reg <= `CCB_OFF_RST;
      gain_coef_set_one_reg <= GAIN_RST;
      gain_coef_set_two_reg <= GAIN_RST;
      ctrl_reg <= `CCB_CTRL_RST;
      slp_reg <= `CCB_OPT_RST;
    end else if (wr_done) begin
      case (wr_adr)
        // Full word stored; the 20-bit field drops its low nibble.
        `CCB_ADR_OFF1: off1_reg <= wr_al;
        `CCB_ADR_OFF2: off2_reg <= wr_al;
        `CCB_ADR_GAIN_COEF_SET_ONE: gain_coef_set_one_reg <= wr_al;
        `CCB_ADR_GAIN_COEF_SET_TWO: gain_coef_set_two_reg <= wr_al;
        `CCB_ADR_CTRL: ctrl_reg <= (DW == 16) ? rx_new[15:8] : rx_new[7:0];
        `CCB_ADR_OPT: slp_reg <= (DW == 16) ? rx_new[8] : rx_new[0];
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Calibration set choice and correction
  // ----------------------------------------------------------------
  wire [3:0] positive_input_select = ctrl_reg[7:4];
  wire [3:0] op_mode = ctrl_reg[3:0];
  wire set_two = (positive_input_select >= `CCB_SET2_LO) &
                 (positive_input_select <= `CCB_SET2_HI);
  wire [23:0] off_sel = set_two ? off2_reg : off1_reg;
  wire [23:0] gain_sel = set_two ? gain_coef_set_two_reg : gain_coef_set_one_reg;
  wire [23:0] conv_al = conv_data_i & FMASK;

  // Gain is unsigned with unity at the top bit, so the product is shifted back.
  wire signed [24:0] diff = $signed({conv_al[23], conv_al}) - $signed({off_sel[23], off_sel});
  wire signed [49:0] prod = diff * $signed({1'b0, gain_sel});
  wire signed [26:0] scaled = prod[49:`CCB_GAIN_SHIFT];
  wire over = (scaled > $signed({3'b000, `CCB_SAT_MAX}));
  wire under = (scaled < $signed({3'b111, `CCB_SAT_MIN}));
  wire [23:0] sat = over ? `CCB_SAT_MAX : (under ? `CCB_SAT_MIN : scaled[23:0]);

  reg [23:0] corr_reg;
  reg corr_valid_reg;
  reg ready_reg, standby_reg, apd_reg, set_two_reg;

  always @(posedge mclk_i) begin
    if (!rst_n_i) begin
      corr_reg <= 24'h000000;
      corr_valid_reg <= 1'b0;
      data_reg <= 24'h000000;
      ready_reg <= 1'b0;
      standby_reg <= 1'b0;
      apd_reg <= 1'b1;
      set_two_reg <= 1'b0;
    end else begin
      corr_valid_reg <= conv_valid_i & active;
      if (conv_valid_i & active) begin
        corr_reg <= sat & FMASK;
        data_reg <= sat & FMASK;
      end
      ready_reg <= active;
      standby_reg <= (st_reg == ST_STANDBY_PIN);
      apd_reg <= (st_reg != ST_IDLE) |
                 ((op_mode == `CCB_MODE_IDLE) & slp_reg);
      set_two_reg <= set_two;
    end
  end

  assign sdo_o = tx_reg[23];
  assign sdo_oe_o = sdo_oe_reg;
  assign corr_data_o = corr_reg;
  assign corr_valid_o = corr_valid_reg;
  assign ready_o = ready_reg;
  assign standby_o = standby_reg;
  assign analog_pd_o = apd_reg;
  assign cal_set_two_o = set_two_reg;

endmodule // ccb_top

// ### pkg/ccb_regs.vh
// Functional notes
// - Two offset coefficient registers at 0xC and 0xD, read/write, reset zero.
// - 16-bit variant: offset is a 16-bit signed value filling the word.
// - 20-bit variant: signed value in bits 23:4, MSB first, bits 3:0 read zero.
// - 24-bit variant: offset is a 24-bit signed value in bits 23:0.
// - Input select 0x4..0x7 picks set two; every other value picks set one.
// - Each converted result gets offset and gain correction before host readout.
// - Serial input is MSB first and sampled on each falling serial clock edge.
// - Serial clock and input are ignored while chip select is high.
// - Chip select falling edge resets the serial state; a command byte follows.
// - After reset release wait about 600 us, then enter idle.
// - Standby pin high puts the device in standby with everything off.
// - Gain registers of sets one and two at 0x8 and 0x9, unsigned.
// - Idle power-down bit powers analog off when set, only in idle mode 0x0.
`ifndef CCB_REGS_VH
`define CCB_REGS_VH

`define CCB_ADR_CTRL 4'h0
`define CCB_ADR_DATA 4'h1
`define CCB_ADR_OPT 4'h7
`define CCB_ADR_GAIN_COEF_SET_ONE 4'h8
`define CCB_ADR_GAIN_COEF_SET_TWO 4'h9
`define CCB_ADR_OFF1 4'hc
`define CCB_ADR_OFF2 4'hd

`define CCB_OFF_RST 24'h000000
`define CCB_GAIN_RST 24'h800000
`define CCB_GAIN16_RST 24'h000000
`define CCB_CTRL_RST 8'h00
`define CCB_OPT_RST 1'b1
`define CCB_MASK20 24'hfffff0
`define CCB_MASK_ALL 24'hffffff

`define CCB_SET2_LO 4'h4
`define CCB_SET2_HI 4'h7
`define CCB_MODE_IDLE 4'h0

`define CCB_CMD_BITS 6'd8
`define CCB_CMD_RD 7
`define CCB_GAIN_SHIFT 23
`define CCB_SAT_MAX 24'h7fffff
`define CCB_SAT_MIN 24'h800000

`define CCB_STARTUP_US 600
`define CCB_CLK_MHZ 10

`endif

// ### tb/ccb_monitor.sv
module ccb_monitor #(
  parameter STARTUP_CYC = 6000
) (
  // Device ports
  input wire mclk_i,
  input wire rst_n_i,
  input wire chip_select_n_i,
  input wire standby_pin_i,
  input wire conv_valid_i,
  input wire [23:0] corr_data_o,
  input wire corr_valid_o,
  input wire sdo_oe_o,
  input wire ready_o,
  input wire standby_o,
  input wire analog_pd_o,
  input wire cal_set_two_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // --------
  // Checks
  // --------
  int up_cnt;
  always @(posedge mclk_i) begin
    if (!rst_n_i || standby_o) up_cnt <= 0;
    else if (up_cnt < STARTUP_CYC) up_cnt <= up_cnt + 1;
  end
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  property p_corr_go; conv_valid_i && ready_o |=> corr_valid_o; endproperty
  a_corr_go: assert property (p_corr_go) else $error("result missing");
  property p_corr_src; corr_valid_o |-> $past(conv_valid_i); endproperty
  a_corr_src: assert property (p_corr_src) else $error("result without sample");
  property p_hold; !conv_valid_i |=> $stable(corr_data_o); endproperty
  a_hold: assert property (p_hold) else $error("result changed");
  property p_sel; $changed(cal_set_two_o) |-> !chip_select_n_i; endproperty
  a_sel: assert property (p_sel) else $error("set changed outside frame");
  property p_cs_off; chip_select_n_i [*4] |-> ##1 !sdo_oe_o; endproperty
  a_cs_off: assert property (p_cs_off) else $error("driving while deselected");
  property p_standby_pin; standby_pin_i [*4] |-> ##1 standby_o && !ready_o; endproperty
  a_standby_pin: assert property (p_standby_pin) else $error("standby not entered");
  property p_pd; !ready_o ##1 !ready_o |-> analog_pd_o; endproperty
  a_pd: assert property (p_pd) else $error("analog on outside idle");
  property p_start; $rose(ready_o) |-> up_cnt >= STARTUP_CYC - 2; endproperty
  a_start: assert property (p_start) else $error("startup too short");
endmodule // ccb_monitor

bind ccb_top ccb_monitor #(.STARTUP_CYC(STARTUP_CYC)) u_mon (.mclk_i(mclk_i),
  .rst_n_i(rst_n_i), .chip_select_n_i(chip_select_n_i), .standby_pin_i(standby_pin_i),
  .conv_valid_i(conv_valid_i), .corr_data_o(corr_data_o), .corr_valid_o(corr_valid_o),
  .sdo_oe_o(sdo_oe_o), .ready_o(ready_o), .standby_o(standby_o),
  .analog_pd_o(analog_pd_o), .cal_set_two_o(cal_set_two_o));

// ### tb/ccb_host_model.sv
module ccb_host_model (
  // Serial pins
  output logic sck_o,
  output logic sdi_o,
  output logic csn_o,
  input wire sdo_i
);
  timeunit 1ns;
  timeprecision 1ns;
  // --------
  // Frames
  // --------
  initial begin
    sck_o = 1'b1;
    sdi_o = 1'b0;
    csn_o = 1'b1;
  end
  // Read bits are taken just before the next fall, where each one is surely settled.
  task automatic xfer(input logic [7:0] cmd, input logic [23:0] wd, input int nbits,
      input bit cs_off, output logic [23:0] rd);
    logic [31:0] sh;
    sh = {cmd, wd};
    rd = 24'h0;
    #37 csn_o = cs_off;
    for (int i = 0; i < nbits; i++) begin
      sdi_o = sh[31 - i];
      #400;
      if (i >= 8) rd = {rd[22:0], sdo_i};
      sck_o = 1'b0;
      #400 sck_o = 1'b1;
    end
    #400 csn_o = 1'b1;
    sdi_o = ~sdi_o;
    // Chip select stays high long enough for the synchroniser to see the gap.
    #800;
    if (!cmd[7] && cmd[3:1] == 3'b110) #10000;
  endtask
endmodule // ccb_host_model

// ### tb/tb_top.sv
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int SU = 20;
  logic mclk = 0, rst_n = 0, standby_pin = 0, cval = 0;
  logic [23:0] cdat = 24'h0, rd, off [2];
  wire sck, serial_in_line, csn, sdo, sdo_oe, cvalid, rdy, standby_pin_o, pd, set2;
  wire sdo_pin = sdo_oe ? sdo : 1'bz;
  wire [23:0] cdata;
  wire [1:0] k_sck, k_sdi, k_csn, k_sdo, k_oe;
  wire [1:0] k_pin = {k_oe[1] ? k_sdo[1] : 1'bz, k_oe[0] ? k_sdo[0] : 1'bz};
  int errors = 0, samples_checked = 0, seed = 77;
  longint e;
  always #50 mclk = ~mclk;
  `define CHK(n, x, g) begin samples_checked++; if ((x) !== (g)) begin errors++; \
    $display("[ERR] %s exp %h got %h", n, x, g); end end
  ccb_top #(.COEF_W(24), .STARTUP_CYC(SU)) uut (.mclk_i(mclk), .rst_n_i(rst_n),
    .sck_i(sck), .serial_in_line_i(serial_in_line), .chip_select_n_i(csn), .sdo_o(sdo),
    .sdo_oe_o(sdo_oe), .standby_pin_i(standby_pin), .conv_data_i(cdat), .conv_valid_i(cval),
    .corr_data_o(cdata), .corr_valid_o(cvalid), .ready_o(rdy), .standby_o(standby_pin_o),
    .analog_pd_o(pd), .cal_set_two_o(set2));
  ccb_host_model host (.sck_o(sck), .sdi_o(serial_in_line), .csn_o(csn), .sdo_i(sdo_pin));
  ccb_top #(.COEF_W(16), .STARTUP_CYC(SU)) u16 (.mclk_i(mclk), .rst_n_i(rst_n),
    .sck_i(k_sck[0]), .serial_in_line_i(k_sdi[0]), .chip_select_n_i(k_csn[0]),
    .sdo_o(k_sdo[0]), .sdo_oe_o(k_oe[0]), .standby_pin_i(standby_pin), .conv_data_i(cdat),
    .conv_valid_i(cval), .corr_data_o(), .corr_valid_o(), .ready_o(), .standby_o(),
    .analog_pd_o(), .cal_set_two_o());
  ccb_top #(.COEF_W(20), .STARTUP_CYC(SU)) u20 (.mclk_i(mclk), .rst_n_i(rst_n),
    .sck_i(k_sck[1]), .serial_in_line_i(k_sdi[1]), .chip_select_n_i(k_csn[1]),
    .sdo_o(k_sdo[1]), .sdo_oe_o(k_oe[1]), .standby_pin_i(standby_pin), .conv_data_i(cdat),
    .conv_valid_i(cval), .corr_data_o(), .corr_valid_o(), .ready_o(), .standby_o(),
    .analog_pd_o(), .cal_set_two_o());
  ccb_host_model host16 (.sck_o(k_sck[0]), .sdi_o(k_sdi[0]), .csn_o(k_csn[0]),
    .sdo_i(k_pin[0]));
  ccb_host_model host20 (.sck_o(k_sck[1]), .sdi_o(k_sdi[1]), .csn_o(k_csn[1]),
    .sdo_i(k_pin[1]));
  // --------
  // Sequence
  // --------
  task automatic wr(input logic [3:0] a, input logic [23:0] d);
    host.xfer({4'h0, a}, d, 32, 1'b0, rd);
  endtask
  task automatic rdc(input logic [3:0] a, input logic [23:0] x, input string n);
    host.xfer({4'h8, a}, 24'h0, 32, 1'b0, rd);
    `CHK(n, x, rd)
  endtask
  task automatic wait_rdy;
    for (int i = 0; i < 200 && rdy !== 1'b1; i++) @(posedge mclk) #1;
  endtask
  task automatic complete_run;
    if (errors == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    #3000000;
    errors++;
    complete_run;
  end
  initial begin
    repeat (10) @(posedge mclk);
    #1 rst_n = 1;
    repeat (SU - 4) @(posedge mclk);
    #1 `CHK("ready_early", 1'b0, rdy)
    wait_rdy;
    `CHK("ready", 1'b1, rdy)
    `CHK("pd_set", 1'b1, pd)
    rdc(4'hc, 24'h0, "off1_rst");
    rdc(4'hd, 24'h0, "off2_rst");
    rdc(4'h8, 24'h800000, "gain_coef_set_one_rst");
    rdc(4'ha, 24'h0, "unmapped");
    wr(4'h7, 24'h0);
    @(posedge mclk) #1 `CHK("pd_clr", 1'b0, pd)
    for (int s = 0; s < 2; s++) begin
      off[s] = 24'($random(seed));
      if (s == 0) off[0] = {1'b0, off[0][22:1], 1'b1};
      wr(4'(12 + s), off[s]);
    end
    for (int s = 0; s < 2; s++) rdc(4'(12 + s), off[s], "off_rd");
    host16.xfer(8'h07, 24'h0, 24, 1'b0, rd);
    host16.xfer(8'h0c, {off[0][15:0], 8'h00}, 24, 1'b0, rd);
    host16.xfer(8'h8c, 24'h0, 24, 1'b0, rd);
    `CHK("off16_rd", {8'h00, off[0][15:0]}, rd)
    host20.xfer(8'h07, 24'h0, 32, 1'b0, rd);
    host20.xfer(8'h0d, off[1], 32, 1'b0, rd);
    host20.xfer(8'h8d, 24'h0, 32, 1'b0, rd);
    `CHK("off20_rd", off[1] & 24'hfffff0, rd)
    host.xfer(8'h0c, ~off[0], 32, 1'b1, rd);
    host.xfer(8'h0c, ~off[0], 20, 1'b0, rd);
    rdc(4'hc, off[0], "off1_kept");
    for (int c = 0; c < 16; c++) begin
      wr(4'h0, {16'h0, 4'(c), 4'h0});
      @(posedge mclk) #1 `CHK("set_two", (c >= 4 && c < 8), set2)
      cdat = (c == 0) ? 24'h800000 : 24'($random(seed));
      cval = 1;
      @(posedge mclk) #1 cval = 0;
      e = longint'(signed'(cdat)) - longint'(signed'(off[c >= 4 && c < 8]));
      e = e > 64'sh7fffff ? 64'sh7fffff : (e < -64'sh800000 ? -64'sh800000 : e);
      `CHK("corr_valid", 1'b1, cvalid)
      `CHK("corr_data", 24'(e), cdata)
    end
    @(posedge mclk) #1 standby_pin = 1;
    repeat (6) @(posedge mclk);
    #1 `CHK("standby_pin", 1'b1, standby_pin_o)
    `CHK("standby_pin_rdy", 1'b0, rdy)
    standby_pin = 0;
    wait_rdy;
    `CHK("ready_again", 1'b1, rdy)
    complete_run;
  end
endmodule // tb_top
